// ### verilog/ufc_defs.vh
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH
// register map, byte addresses on a 12-bit port
`define UFC_A_CTRL 12'h000
`define UFC_A_STAT 12'h004
`define UFC_RGN_FRM 4'h1
`define UFC_RGN_SEG 3'b010
`define UFC_RGN_MEM 2'b10
// table sizes
`define UFC_NFRM 4'd15
`define UFC_LAST_FRM 4'd14
`define UFC_NSEG 4'd8
`define UFC_MAX_CH 3'd3
// frame word fields
`define UFC_F_LEN 26:24
`define UFC_F_DIR 1:0
`define UFC_F_NSEG 11:8
`define UFC_F_BCCEN 16
`define UFC_F_BCCPOS 18:17
`define UFC_F_BCCASC 19
`define UFC_F_RULE 2:0
`define UFC_F_COMP 5:4
`define UFC_F_MOP 7:6
`define UFC_F_MVAL 15:8
`define UFC_F_RS 21:16
`define UFC_F_RE 29:24
`define UFC_F_SLEN 7:0
`define UFC_F_SOFF 15:8
`define UFC_F_SARR 16
`define UFC_F_SCONV 17
// codes
`define UFC_DIR_NONE 2'd0
`define UFC_DIR_SEND 2'd1
`define UFC_DIR_RECV 2'd2
`define UFC_R_DEF 3'd0
`define UFC_R_SUM2 3'd2
`define UFC_R_XOR1 3'd3
`define UFC_R_XOR2 3'd4
`define UFC_R_MUL1 3'd5
`define UFC_R_MUL2 3'd6
`define UFC_C_ONE 2'd1
`define UFC_C_TWO 2'd2
`define UFC_M_XOR 2'd0
`define UFC_M_OR 2'd1
`define UFC_M_AND 2'd2
`define UFC_P_HDR 2'd0
`define UFC_P_SEG 2'd1
`define UFC_P_TAIL 2'd2
`define UFC_LIM_ASC 9'd128
`define UFC_LIM_HEX 9'd256
`define UFC_E_BUSY 8'h06
`define UFC_E_PARAM 8'h09
`define UFC_E_FTYPE 8'h10
`define UFC_E_SIZE 8'h11
`endif

// ### verilog/ufc_user_frame_codec.v
// Overview of operation
// - frame chars: letter, digit, 00-1f or 7f
// - header and tail hold three chars at most
// - direction undefined, send or receive; undefined idles
// - body is up to eight segments
// - constant segments emit their stored byte sequence
// - array option: ascii on send, hex on receive
// - array segment length counted in bytes
// - check inserted at tail marker when present
// - ascii check two bytes, binary check one
// - default sums second byte up to marker
// - first additive sums over configured range
// - first xor rule xors the configured range
// - first multiplicative rule multiplies the range
// - second variants add the mask step
// - range ends are part plus element index
// - optional one or two complement before mask
// - mask by xor, or, and with constant
// - frame at most 128 ascii, 256 hex bytes
// - received frame matched, data stored on match
// - match pulses flag n for entry n
// - frame list holds fifteen entries
// - done one cycle; error bit and code
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ufc_defs.vh"
module ufc_user_frame_codec (
  input wire clk,
  input wire rstn,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg [7:0] txData,
  output reg txValid,
  input wire txReady,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire rxEnd,
  output reg sendDone,
  output reg [14:0] matchFlag
);
  localparam S_IDLE = 1'b0;
  localparam S_WALK = 1'b1;
  localparam M_TX = 2'd0;
  localparam M_CHK = 2'd1;
  localparam M_STORE = 2'd2;

  ////////////////////////////////////////////////////////////////
  function chOk(input [7:0] c);
    chOk = (c <= 8'h1f) || (c == 8'h7f) || (c >= 8'h30 && c <= 8'h39) ||
      (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
  endfunction

  // header and tail words share one layout
  function partOk(input [31:0] w);
    partOk = (w[`UFC_F_LEN] <= `UFC_MAX_CH) &&
      (w[`UFC_F_LEN] < 3'd1 || chOk(w[7:0])) &&
      (w[`UFC_F_LEN] < 3'd2 || chOk(w[15:8])) &&
      (w[`UFC_F_LEN] < 3'd3 || chOk(w[23:16]));
  endfunction

  function [7:0] pick(input [26:0] w, input [1:0] i);
    pick = (i == 2'd0) ? w[7:0] : (i == 2'd1) ? w[15:8] : w[23:16];
  endfunction

  function [7:0] asc(input [3:0] n);
    asc = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
  endfunction

  function [3:0] hexv(input [7:0] c);
    hexv = (c >= 8'h61) ? c[3:0] + 4'h9 : (c >= 8'h41) ? c[3:0] + 4'h9 : c[3:0];
  endfunction

  function [7:0] accInit(input [2:0] r);
    accInit = (r == `UFC_R_MUL1 || r == `UFC_R_MUL2) ? 8'h01 : 8'h00;
  endfunction

  function [7:0] accStep(input [7:0] a, input [7:0] b, input [2:0] r);
    reg [15:0] p;
    begin
      p = a * b;
      if (r == `UFC_R_XOR1 || r == `UFC_R_XOR2)
        accStep = a ^ b;
      else if (r == `UFC_R_MUL1 || r == `UFC_R_MUL2)
        accStep = p[7:0];
      else
        accStep = a + b;
    end
  endfunction

  function [7:0] finChk(input [7:0] a, input [29:0] c);
    reg [7:0] v;
    begin
      case (c[`UFC_F_COMP])
        `UFC_C_ONE: v = ~a;
        `UFC_C_TWO: v = 8'h00 - a;
        default: v = a;
      endcase
      if (c[`UFC_F_RULE] == `UFC_R_SUM2 || c[`UFC_F_RULE] == `UFC_R_XOR2 ||
        c[`UFC_F_RULE] == `UFC_R_MUL2)
      begin
        case (c[`UFC_F_MOP])
          `UFC_M_XOR: v = v ^ c[`UFC_F_MVAL];
          `UFC_M_OR: v = v | c[`UFC_F_MVAL];
          default: v = v & c[`UFC_F_MVAL];
        endcase
      end
      finChk = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // configuration tables, fifteen frames of eight segments
  reg [26:0] hdr_r [0:14];
  reg [26:0] tail_r [0:14];
  reg [19:0] fctl_r [0:14];
  reg [29:0] chk_r [0:14];
  reg [17:0] seg_r [0:127];
  reg [7:0] mem_r [0:255];
  reg [7:0] rxb_r [0:255];
  reg asciiMode_r;
  reg cfgErr_r;
  reg st_r;
  reg [1:0] mode_r;
  reg [3:0] frm_r;
  reg [1:0] part_r;
  reg [3:0] el_r;
  reg [7:0] bi_r;
  reg nib_r;
  reg [8:0] pos_r;
  reg [7:0] acc_r;
  reg ok_r;
  reg past_r;
  reg [3:0] hi_r;
  reg [8:0] rxLen_r;
  reg rxOvf_r;
  reg rxPend_r;
  reg sendErr_r;
  reg [7:0] errCode_r;
  reg [3:0] lastMatch_r;
  integer i;

  wire [3:0] fIdx = addr[7:4];
  wire frmHit = (addr[11:8] == `UFC_RGN_FRM) && (fIdx < `UFC_NFRM);
  wire [8:0] lim = asciiMode_r ? `UFC_LIM_ASC : `UFC_LIM_HEX;

  // table writes; a rejected word leaves the old entry in place
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      asciiMode_r <= 1'b0;
      cfgErr_r <= 1'b0;
      for (i = 0; i < 15; i = i + 1)
      begin
        hdr_r[i] <= 27'h0;
        tail_r[i] <= 27'h0;
        fctl_r[i] <= 20'h0; // direction starts undefined
        chk_r[i] <= 30'h0;
      end
      for (i = 0; i < 128; i = i + 1)
        seg_r[i] <= 18'h0;
    end
    else if (wr)
    begin
      if (addr == `UFC_A_CTRL)
        asciiMode_r <= wdata[8];
      if (addr == `UFC_A_STAT && wdata[3])
        cfgErr_r <= 1'b0;
      if (frmHit)
      begin
        case (addr[3:2])
          2'd0:
            if (partOk(wdata)) hdr_r[fIdx] <= wdata[26:0];
            else cfgErr_r <= 1'b1;
          2'd1:
            if (partOk(wdata)) tail_r[fIdx] <= wdata[26:0];
            else cfgErr_r <= 1'b1;
          2'd2:
            if (wdata[`UFC_F_NSEG] <= `UFC_NSEG) fctl_r[fIdx] <= wdata[19:0];
            else cfgErr_r <= 1'b1;
          default:
            chk_r[fIdx] <= wdata[29:0];
        endcase
      end
      if (addr[11:9] == `UFC_RGN_SEG)
        seg_r[addr[8:2]] <= wdata[17:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // what the current frame element looks like
  reg [26:0] fh;
  reg [26:0] ft;
  reg [19:0] fc;
  reg [29:0] ck;
  reg [17:0] sd;
  reg have;
  reg chkEl;
  reg arr;
  reg twoCh;
  reg itemDone;
  reg [7:0] wb;
  reg [7:0] fin;
  reg inRg;
  wire [8:0] maw = {1'b0, sd[`UFC_F_SOFF]} + {1'b0, bi_r};
  wire [7:0] ma = maw[7:0];
  wire [8:0] biNext = {1'b0, bi_r} + 9'd1;
  wire [7:0] rb = rxb_r[pos_r[7:0]];
  wire [5:0] key = {part_r, el_r};
  wire dirOk = (fc[`UFC_F_DIR] == ((mode_r == M_TX) ? `UFC_DIR_SEND : `UFC_DIR_RECV));
  wire go = (mode_r != M_TX) || !txValid || txReady;
  wire endFrm = !dirOk || (part_r == `UFC_P_TAIL && !have);
  wire [7:0] ab = (mode_r == M_TX) ? wb : rb;

  always @*
  begin
    fh = hdr_r[frm_r];
    ft = tail_r[frm_r];
    fc = fctl_r[frm_r];
    ck = chk_r[frm_r];
    sd = seg_r[{frm_r, el_r[2:0]}];
    fin = finChk(acc_r, ck);
    have = 1'b0;
    chkEl = 1'b0;
    arr = 1'b0;
    twoCh = 1'b0;
    itemDone = 1'b1;
    wb = 8'h00;
    case (part_r)
      `UFC_P_HDR:
      begin
        have = el_r < {1'b0, fh[`UFC_F_LEN]};
        wb = pick(fh, el_r[1:0]);
      end
      `UFC_P_SEG:
      begin
        have = (el_r < fc[`UFC_F_NSEG]) && (sd[`UFC_F_SLEN] != 8'h00);
        arr = sd[`UFC_F_SARR];
        twoCh = arr && sd[`UFC_F_SCONV];
        wb = twoCh ? asc(nib_r ? mem_r[ma][3:0] : mem_r[ma][7:4]) : mem_r[ma];
        itemDone = (biNext == {1'b0, sd[`UFC_F_SLEN]}) && (!twoCh || nib_r);
      end
      `UFC_P_TAIL:
      begin
        have = el_r < {1'b0, ft[`UFC_F_LEN]};
        chkEl = fc[`UFC_F_BCCEN] && (el_r[1:0] == fc[`UFC_F_BCCPOS]);
        twoCh = chkEl && fc[`UFC_F_BCCASC];
        if (chkEl)
          wb = twoCh ? asc(nib_r ? fin[3:0] : fin[7:4]) : fin;
        else
          wb = pick(ft, el_r[1:0]);
        itemDone = !twoCh || nib_r;
      end
      default:
        have = 1'b0;
    endcase
    if (ck[`UFC_F_RULE] == `UFC_R_DEF)
      inRg = pos_r != 9'd0; // from the second byte
    else
      inRg = (key >= ck[`UFC_F_RS]) && (key <= ck[`UFC_F_RE]);
  end

  // array data landing from a matched frame
  wire memWe = (st_r == S_WALK) && (mode_r == M_STORE) && !endFrm && have &&
    (part_r == `UFC_P_SEG) && arr && (!twoCh || nib_r);
  wire [7:0] memWd = twoCh ? {hi_r, hexv(rb)} : rb;
  wire rxTake = rxValid && (st_r == S_IDLE || mode_r == M_TX) && !rxOvf_r && (rxLen_r < lim);

  // data memory and receive buffer hold no control state, so no reset
  always @(posedge clk)
  begin
    if (memWe)
      mem_r[ma] <= memWd;
    else if (wr && addr[11:10] == `UFC_RGN_MEM)
      mem_r[addr[9:2]] <= wdata[7:0];
    if (rxTake)
      rxb_r[rxLen_r[7:0]] <= rxData;
  end

  ////////////////////////////////////////////////////////////////
  task restart(input [3:0] f, input [1:0] m);
    begin
      st_r <= S_WALK;
      mode_r <= m;
      frm_r <= f;
      part_r <= `UFC_P_HDR;
      el_r <= 4'h0;
      bi_r <= 8'h00;
      nib_r <= 1'b0;
      pos_r <= 9'd0;
      acc_r <= accInit(chk_r[f][`UFC_F_RULE]);
      ok_r <= 1'b1;
      past_r <= 1'b0;
    end
  endtask

  // frame walker: sends, checks and stores frames element by element
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= S_IDLE;
      mode_r <= M_TX;
      frm_r <= 4'h0;
      part_r <= `UFC_P_HDR;
      el_r <= 4'h0;
      bi_r <= 8'h00;
      nib_r <= 1'b0;
      pos_r <= 9'd0;
      acc_r <= 8'h00;
      ok_r <= 1'b0;
      past_r <= 1'b0;
      hi_r <= 4'h0;
      rxLen_r <= 9'd0;
      rxOvf_r <= 1'b0;
      rxPend_r <= 1'b0;
      sendErr_r <= 1'b0;
      errCode_r <= 8'h00;
      lastMatch_r <= 4'h0;
      txData <= 8'h00;
      txValid <= 1'b0;
      sendDone <= 1'b0;
      matchFlag <= 15'h0;
    end
    else
    begin
      sendDone <= 1'b0;
      matchFlag <= 15'h0;
      if (txValid && txReady)
        txValid <= 1'b0;
      if (wr && addr == `UFC_A_STAT && wdata[2])
        sendErr_r <= 1'b0;
      // receive side collects bytes until the link marks the end
      if (rxTake)
        rxLen_r <= rxLen_r + 9'd1;
      else if (rxValid && (st_r == S_IDLE || mode_r == M_TX))
        rxOvf_r <= 1'b1; // oversize frame is dropped
      if (rxEnd && (st_r == S_IDLE || mode_r == M_TX))
      begin
        if (rxOvf_r || rxLen_r == 9'd0)
        begin
          rxLen_r <= 9'd0;
          rxOvf_r <= 1'b0;
        end
        else
          rxPend_r <= 1'b1;
      end
      case (st_r)
        S_IDLE:
        begin
          if (wr && addr == `UFC_A_CTRL && wdata[0])
          begin
            if (wdata[7:4] > `UFC_LAST_FRM ||
              fctl_r[wdata[7:4]][`UFC_F_DIR] != `UFC_DIR_SEND)
            begin
              sendErr_r <= 1'b1;
              errCode_r <= `UFC_E_FTYPE;
            end
            else if (fctl_r[wdata[7:4]][`UFC_F_BCCEN] &&
              chk_r[wdata[7:4]][`UFC_F_RULE] != `UFC_R_DEF &&
              chk_r[wdata[7:4]][`UFC_F_RS] > chk_r[wdata[7:4]][`UFC_F_RE])
            begin
              sendErr_r <= 1'b1;
              errCode_r <= `UFC_E_PARAM;
            end
            else
              restart(wdata[7:4], M_TX);
          end
          else if (rxPend_r)
          begin
            rxPend_r <= 1'b0;
            restart(4'h0, M_CHK);
          end
        end
        S_WALK:
        begin
          if (wr && addr == `UFC_A_CTRL && wdata[0])
          begin
            sendErr_r <= 1'b1;
            errCode_r <= `UFC_E_BUSY;
          end
          if (go && endFrm)
          begin
            if (mode_r == M_TX)
            begin
              st_r <= S_IDLE;
              sendDone <= 1'b1; // one cycle
            end
            else if (mode_r == M_CHK && dirOk && ok_r && pos_r == rxLen_r)
              restart(frm_r, M_STORE); // second pass writes data
            else if (mode_r == M_STORE)
            begin
              st_r <= S_IDLE;
              matchFlag <= 15'h0001 << frm_r;
              lastMatch_r <= frm_r;
              rxLen_r <= 9'd0;
            end
            else if (frm_r == `UFC_LAST_FRM)
            begin
              st_r <= S_IDLE;
              rxLen_r <= 9'd0;
            end
            else
              restart(frm_r + 4'h1, M_CHK);
          end
          else if (go && !have)
          begin
            // empty element: move to next segment or next part
            if (part_r == `UFC_P_SEG && el_r < fc[`UFC_F_NSEG])
              el_r <= el_r + 4'h1;
            else
            begin
              part_r <= part_r + 2'd1;
              el_r <= 4'h0;
            end
          end
          else if (go && mode_r == M_TX && pos_r >= lim)
          begin
            st_r <= S_IDLE;
            sendErr_r <= 1'b1;
            errCode_r <= `UFC_E_SIZE;
          end
          else if (go)
          begin
            pos_r <= pos_r + 9'd1;
            if (mode_r == M_TX)
            begin
              txData <= wb;
              txValid <= 1'b1;
            end
            if (mode_r == M_CHK && (pos_r >= rxLen_r || (!arr && rb != wb)))
              ok_r <= 1'b0;
            if (twoCh && !nib_r)
              hi_r <= hexv(rb);
            if (inRg && !chkEl && !past_r)
              acc_r <= accStep(acc_r, ab, ck[`UFC_F_RULE]);
            if (chkEl && itemDone)
              past_r <= 1'b1; // stop at the marker
            if (itemDone)
            begin
              el_r <= el_r + 4'h1;
              bi_r <= 8'h00;
              nib_r <= 1'b0;
            end
            else
            begin
              nib_r <= twoCh ? !nib_r : 1'b0; // high nibble first
              if (!twoCh || nib_r)
                bi_r <= biNext[7:0];
            end
          end
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe, zero when unmapped
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0;
    else if (rd)
    begin
      rdata <= 32'h0;
      if (addr == `UFC_A_CTRL)
        rdata <= {23'h0, asciiMode_r, 8'h00};
      else if (addr == `UFC_A_STAT)
        rdata <= {3'h0, rxLen_r, lastMatch_r, errCode_r, 3'h0, rxPend_r, cfgErr_r, sendErr_r, mode_r == M_TX, st_r};
      else if (frmHit)
      begin
        case (addr[3:2])
          2'd0: rdata <= {5'h0, hdr_r[fIdx]};
          2'd1: rdata <= {5'h0, tail_r[fIdx]};
          2'd2: rdata <= {12'h0, fctl_r[fIdx]};
          default: rdata <= {2'h0, chk_r[fIdx]};
        endcase
      end
      else if (addr[11:9] == `UFC_RGN_SEG)
        rdata <= {14'h0, seg_r[addr[8:2]]};
      else if (addr[11:10] == `UFC_RGN_MEM)
        rdata <= {24'h0, mem_r[addr[9:2]]};
    end
  end
endmodule

// ### sim/ufc_user_frame_codec_checker.sv
`timescale 1ns/1ps
module ufc_user_frame_codec_checker (
  input wire clk,
  input wire rstn,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [7:0] txData,
  input wire txValid,
  input wire txReady,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire rxEnd,
  input wire sendDone,
  input wire [14:0] matchFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [9:0] txCnt_r;
  ////////////////////////////////////////////////////////////////
  sequence stallSeq;
    txValid && !txReady;
  endsequence
  sequence heldSeq;
    txValid && $stable(txData);
  endsequence
  // bytes taken since the last start; a refused start also clears it, so the bound stays loose
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      txCnt_r <= 10'h000;
    else if (wr && addr == 12'h000 && wdata[0])
      txCnt_r <= 10'h000;
    else if (txValid && txReady)
      txCnt_r <= txCnt_r + 10'h001;
  end
  ////////////////////////////////////////////////////////////////
  tx_hold_a: assert property (stallSeq |=> heldSeq)
    else $error("tx byte changed while stalled");
  done_pulse_a: assert property (sendDone |=> !sendDone)
    else $error("send done longer than one cycle");
  done_idle_a: assert property (sendDone |-> !txValid)
    else $error("send done with a byte still pending");
  match_pulse_a: assert property (matchFlag != 15'h0000 |=> matchFlag == 15'h0000)
    else $error("match flag longer than one cycle");
  match_single_a: assert property ($onehot0(matchFlag))
    else $error("several match flags at once");
  reset_quiet_a: assert property (disable iff (1'b0) !rstn |-> !txValid && !sendDone && matchFlag == 15'h0)
    else $error("outputs active in reset");
  frame_limit_a: assert property (txCnt_r <= 10'd256)
    else $error("frame longer than limit");
  unmapped_read_a: assert property (rd && addr == 12'h1f0 |=> rdata == 32'h0)
    else $error("frame entry fifteen answered");
endmodule
bind ufc_user_frame_codec ufc_user_frame_codec_checker ufc_user_frame_codec_checker_inst (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
  .rxEnd(rxEnd), .sendDone(sendDone), .matchFlag(matchFlag));

// ### sim/ufc_serial_partner.sv
`timescale 1ns/1ps
module ufc_serial_partner (
  input logic clk,
  input logic rstn,
  input logic slow,
  input logic [7:0] txData,
  input logic txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxEnd
);
  logic [7:0] got[$];
  int phase;
  initial
  begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxEnd = 1'b0;
  end
  // slow mode takes one byte in three cycles to stress the hold
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      txReady <= 1'b0;
      phase <= 0;
    end
    else
    begin
      if (txValid && txReady)
        got.push_back(txData);
      phase <= (phase + 1) % 3;
      txReady <= !slow || phase == 1;
    end
  end
  // frames kept short; the idle line shows the inverse of the last byte
  task automatic sendFrame(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(posedge clk);
      rxData <= b[i];
      rxValid <= 1'b1;
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxData <= ~rxData;
    rxEnd <= 1'b1;
    @(posedge clk);
    rxEnd <= 1'b0;
  endtask
endmodule

// ### sim/ufc_user_frame_codec_test.sv
`timescale 1ns/1ps
module ufc_user_frame_codec_test;
  typedef struct {logic [31:0] chk; logic asc; logic [15:0] exp;} ufc_row_t;
  logic clk, rstn, wr, rd, slow, txReady, txValid, rxValid, rxEnd, sendDone;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [7:0] txData, rxData;
  logic [14:0] matchFlag, seen;
  logic [7:0] e[$];
  int failures, n_compared, i;
  // frame 2: 05, constant 31 32 33 34, tail 04 and check
  ufc_row_t rows[16] = '{
    '{32'h00000000, 1'b0, 16'h00ce}, '{32'h20000001, 1'b0, 16'h00d3},
    '{32'h20000003, 1'b0, 16'h0005}, '{32'h20000005, 1'b0, 16'h0060},
    '{32'h10100001, 1'b0, 16'h00ca}, '{32'h20000011, 1'b0, 16'h002c},
    '{32'h20000021, 1'b0, 16'h002d}, '{32'h20000081, 1'b0, 16'h00d3},
    '{32'h2000ff02, 1'b0, 16'h002c}, '{32'h20000f42, 1'b0, 16'h00df},
    '{32'h20000f82, 1'b0, 16'h0003}, '{32'h2000f094, 1'b0, 16'h00f0},
    '{32'h20000f06, 1'b0, 16'h006f}, '{32'h00000000, 1'b1, 16'h4345},
    '{32'h20000001, 1'b1, 16'h4433}, '{32'h20000005, 1'b1, 16'h3630}};
  ufc_user_frame_codec ufc_user_frame_codec_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd), .sendDone(sendDone), .matchFlag(matchFlag));
  ufc_serial_partner ufc_serial_partner_inst (.clk(clk), .rstn(rstn), .slow(slow), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // bounded poll; stops at the first edge showing the event
  task automatic waitEv(input logic rx, input int lim);
    int k;
    seen = 15'h0;
    for (k = 0; k < lim && seen === 15'h0; k++)
    begin
      @(posedge clk);
      #1;
      seen = rx ? matchFlag : {14'h0, sendDone};
    end
  endtask
  // a second start while busy must be refused, not restart the frame
  task automatic sendCheck(input logic twice);
    ufc_serial_partner_inst.got.delete();
    wrReg(12'h000, 32'h21);
    if (twice)
      wrReg(12'h000, 32'h21);
    waitEv(1'b0, 3000);
    if (seen !== 15'h1)
    begin
      failures++;
      stop_test();
    end
    check(32'(ufc_serial_partner_inst.got.size()), 32'(e.size()));
    foreach (e[k])
      check({24'h0, ufc_serial_partner_inst.got[k]}, {24'h0, e[k]});
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rstn, wr, rd, slow, addr, wdata, failures, n_compared} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // idle after reset; bit 1 follows the walker mode, which rests on send
    rdReg(12'h004, v);
    check(v, 32'h2);
    rdReg(12'h1f0, v);
    check(v, 32'h0);
    wrReg(12'h120, 32'h01000005);
    wrReg(12'h124, 32'h02000004);
    wrReg(12'h440, 32'h00000004);
    for (i = 0; i < 4; i++)
      wrReg(12'h800 + 12'(i * 4), 32'h31 + 32'(i));
    for (i = 0; i < 16; i++)
    begin
      slow <= i[0];
      wrReg(12'h128, {12'h0, rows[i].asc, 19'h30101});
      wrReg(12'h12c, rows[i].chk);
      e = '{8'h05, 8'h31, 8'h32, 8'h33, 8'h34, 8'h04};
      if (rows[i].asc)
        e.push_back(rows[i].exp[15:8]);
      e.push_back(rows[i].exp[7:0]);
      sendCheck(1'b0);
    end
    // refused table words: four chars, a bad char, nine segments; then a legal three
    wrReg(12'h140, 32'h04000005);
    rdReg(12'h004, v);
    check(v[3], 1);
    wrReg(12'h004, 32'h8);
    wrReg(12'h140, 32'h01000021);
    rdReg(12'h004, v);
    check(v[3], 1);
    wrReg(12'h004, 32'h8);
    wrReg(12'h148, 32'h00000901);
    rdReg(12'h004, v);
    check(v[3], 1);
    wrReg(12'h004, 32'h8);
    wrReg(12'h140, 32'h037f4105);
    rdReg(12'h004, v);
    check(v[3], 0);
    // undefined frame and frame fifteen refuse to send
    for (i = 5; i < 16; i += 10)
    begin
      wrReg(12'h000, {24'h0, 4'(i), 4'h1});
      rdReg(12'h004, v);
      check({v[15:8], 7'h0, v[2]}, 16'h1001);
      wrReg(12'h004, 32'h4);
    end
    // converted array: 5a goes out as two characters
    wrReg(12'h440, 32'h00033001);
    wrReg(12'h8c0, 32'h5a);
    wrReg(12'h128, 32'h00030101);
    wrReg(12'h12c, 32'h0);
    e = '{8'h05, 8'h35, 8'h41, 8'h04, 8'h7a};
    sendCheck(1'b1);
    rdReg(12'h004, v);
    check({v[15:8], 7'h0, v[2]}, 16'h0601);
    // receive frame 3 with a two byte array at offset 20
    wrReg(12'h130, 32'h01000005);
    wrReg(12'h134, 32'h02000004);
    wrReg(12'h138, 32'h00030102);
    wrReg(12'h13c, 32'h0);
    wrReg(12'h460, 32'h00012002);
    ufc_serial_partner_inst.sendFrame('{8'h05, 8'haa, 8'hbb, 8'h04, 8'h69});
    waitEv(1'b1, 3000);
    check(seen, 15'h0008);
    rdReg(12'h880, v);
    check(v[7:0], 8'haa);
    rdReg(12'h884, v);
    check(v[7:0], 8'hbb);
    // a wrong check byte must neither flag nor store
    wrReg(12'h880, 32'h0);
    ufc_serial_partner_inst.sendFrame('{8'h05, 8'haa, 8'hbb, 8'h04, 8'h68});
    waitEv(1'b1, 600);
    check(seen, 15'h0);
    rdReg(12'h880, v);
    check(v[7:0], 8'h00);
    stop_test();
  end
endmodule
